/* hcfd_pkg.sv */
// Constants, field masks and bus carrier types for the host command flag decoder.
// Notes on behaviour
// RULE1: Restart bit restarts stack, re-reads configuration, drops all connections at once.
// RULE2: Inhibit bit forbids opening connections and closes the open ones.
// RULE3: Permit and inhibit together in one write: permit wins, inhibit ignored.
// RULE4: Tool erase deletes tool flash configuration, then clears flash flag, keeps running.
// RULE5: Host must reset the device after tool erase to start unconfigured.
// RULE6: Store bit writes host-modified ranges 100-199 and 300-987 into flash.
// RULE7: Store with tool configuration still present is answered with an exception.
// RULE8: A stored configuration takes effect only at restart, reset or power cycle.
// RULE9: Lock bit makes configuration register writes raise exceptions; lock flag shown.
// RULE10: Unlock bit removes configuration write protection and updates lock flag.
// RULE11: Lock and unlock together in one write: unlock wins.
// RULE12: Watchdog enable bit activates the watchdog and sets its status flag.
// RULE13: Watchdog disable bit deactivates the watchdog and updates its status flag.
// RULE14: Watchdog enable and disable together: disable wins.
// RULE15: Host erase deletes stored host copy, then clears host flag, keeps configuration.
// RULE16: Host erase leaves the stack's own persistent data untouched.
// RULE17: Host always writes zero to reserved bit 13.
// RULE18: Bit 14 or 15 set: whole word is a fieldbus code, no flag decode.
// RULE19: Fieldbus codes honoured only with PROFINET IO device firmware, else unsupported.
// RULE20: Flags clear automatically after execution; a write of zero is ignored.
// RULE21: While permit is in force the firmware tries to open connections.
// RULE22: Bit 0 causes an immediate device reset with no response to the host.
// RULE23: One written word is decoded atomically, all flags resolved together.
// RULE24: Each flag stays set until its action has fully completed.
package hcfd_pkg;

    localparam logic [15:0] HCFD_CMD_ADDR      = 16'h07CF;
    localparam logic [15:0] HCFD_ZERO          = 16'h0000;

    localparam logic [15:0] HCFD_M_RESET       = 16'h0001;
    localparam logic [15:0] HCFD_M_PERMIT      = 16'h0008;
    localparam logic [15:0] HCFD_M_RESTART     = 16'h0010;
    localparam logic [15:0] HCFD_M_INHIBIT     = 16'h0020;
    localparam logic [15:0] HCFD_M_TOOL_ERASE  = 16'h0040;
    localparam logic [15:0] HCFD_M_STORE       = 16'h0080;
    localparam logic [15:0] HCFD_M_LOCK        = 16'h0100;
    localparam logic [15:0] HCFD_M_UNLOCK      = 16'h0200;
    localparam logic [15:0] HCFD_M_WDOG_EN     = 16'h0400;
    localparam logic [15:0] HCFD_M_WDOG_DIS    = 16'h0800;
    localparam logic [15:0] HCFD_M_HOST_ERASE  = 16'h1000;
    localparam logic [15:0] HCFD_M_RESERVED    = 16'h2000;
    localparam logic [15:0] HCFD_M_FIELDBUS    = 16'hC000;

    localparam logic [15:0] HCFD_CFG_A_LO      = 16'h0064;
    localparam logic [15:0] HCFD_CFG_A_HI      = 16'h00C7;
    localparam logic [15:0] HCFD_CFG_B_LO      = 16'h012C;
    localparam logic [15:0] HCFD_CFG_B_HI      = 16'h03DB;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } hcfd_bus_req_t;

    typedef struct packed {
        logic        ack;
        logic        exc;
        logic [15:0] rdata;
    } hcfd_bus_rsp_t;

endpackage

/* hcfd_job.sv */
// Pending tracker for one long-running command: one request pulse, busy until done.
`timescale 1ns/10ps
module hcfd_job (
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // Control
    input  wire logic start,
    input  wire logic done,
    // Status
    output logic      busy,
    output logic      req
);
    typedef struct packed {
        logic busy;
        logic req;
    } hcfd_job_st_t;

    hcfd_job_st_t st_r;
    hcfd_job_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.req = 1'b0;
        if (st_r.busy && done) begin
            st_nxt.busy = 1'b0; // RULE24
        end
        // A start while the same job is pending is absorbed by it.
        if (start && !st_r.busy) begin
            st_nxt.busy = 1'b1;
            st_nxt.req  = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign busy = st_r.busy;
    assign req  = st_r.req;
endmodule

/* hcfd_range.sv */
// Inclusive address window match.
`timescale 1ns/10ps
module hcfd_range #(
    parameter logic [15:0] LO = 16'h0000,
    parameter logic [15:0] HI = 16'hFFFF
) (
    // Address under test
    input  wire logic [15:0] addr,
    // Match
    output logic             hit
);
    assign hit = (addr >= LO) && (addr <= HI);
endmodule

/* hcfd_top.sv */
// Command flag word decoder with status flags and action requests.
`timescale 1ns/10ps
module hcfd_top (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   nrst,
    // Host register access
    input  wire hcfd_pkg::hcfd_bus_req_t bus_req,
    output hcfd_pkg::hcfd_bus_rsp_t     bus_rsp,
    // Firmware environment
    input  wire logic                   fw_is_profinet,
    input  wire logic                   tool_config_loaded,
    input  wire logic                   tool_erase_done,
    input  wire logic                   store_done,
    input  wire logic                   host_erase_done,
    // Immediate actions
    output logic                        device_reset_req,
    output logic                        stack_restart_req,
    output logic                        conn_drop_req,
    output logic                        net_open_enable,
    // Status flags
    output logic                        watchdog_active,
    output logic                        config_write_lock,
    output logic                        flash_config_present_flag,
    output logic                        host_config_present_flag,
    output logic                        active_config_is_host,
    // Flash jobs
    output logic                        tool_erase_req,
    output logic                        store_req,
    output logic                        host_erase_req,
    // Fieldbus specific command
    output logic                        fb_cmd_valid,
    output logic [15:0]                 fb_cmd_code
);
    import hcfd_pkg::*;

    typedef struct packed {
        logic          dev_reset;
        logic          restart;
        logic          drop;
        logic          net_open;
        logic          wdg;
        logic          lock;
        logic          flash_cfg;
        logic          host_cfg;
        logic          act_host;
        logic [15:0]   shown;
        logic          fb_valid;
        logic [15:0]   fb_code;
        hcfd_bus_rsp_t rsp;
    } hcfd_state_t;

    hcfd_state_t st_r;
    hcfd_state_t st_nxt;

    logic        in_cfg_a;
    logic        in_cfg_b;
    logic        tool_busy;
    logic        store_busy;
    logic        herase_busy;
    logic        tool_start;
    logic        store_start;
    logic        herase_start;
    logic        tool_fin;
    logic        store_fin;
    logic        herase_fin;
    logic [15:0] w;
    logic        cmd_hit;
    logic        cfg_hit;

    assign w       = bus_req.wdata;
    assign cmd_hit = bus_req.addr == HCFD_CMD_ADDR;
    assign cfg_hit = in_cfg_a || in_cfg_b;

    assign tool_fin   = tool_busy && tool_erase_done;
    assign store_fin  = store_busy && store_done;
    assign herase_fin = herase_busy && host_erase_done;

    hcfd_range #(
        .LO (HCFD_CFG_A_LO),
        .HI (HCFD_CFG_A_HI)
    ) u_range_a (
        .addr (bus_req.addr),
        .hit  (in_cfg_a)
    );

    hcfd_range #(
        .LO (HCFD_CFG_B_LO),
        .HI (HCFD_CFG_B_HI)
    ) u_range_b (
        .addr (bus_req.addr),
        .hit  (in_cfg_b)
    );

    hcfd_job u_tool_job (
        .clk   (clk),
        .nrst  (nrst),
        .start (tool_start),
        .done  (tool_erase_done),
        .busy  (tool_busy),
        .req   (tool_erase_req)
    );

    hcfd_job u_store_job (
        .clk   (clk),
        .nrst  (nrst),
        .start (store_start),
        .done  (store_done),
        .busy  (store_busy),
        .req   (store_req)
    );

    hcfd_job u_herase_job (
        .clk   (clk),
        .nrst  (nrst),
        .start (herase_start),
        .done  (host_erase_done),
        .busy  (herase_busy),
        .req   (host_erase_req)
    );

    always_comb begin
        st_nxt           = st_r;
        st_nxt.dev_reset = 1'b0;
        st_nxt.restart   = 1'b0;
        st_nxt.drop      = 1'b0;
        st_nxt.fb_valid  = 1'b0;
        st_nxt.rsp.ack   = 1'b0;
        st_nxt.rsp.exc   = 1'b0;
        st_nxt.rsp.rdata = HCFD_ZERO;
        // Immediate flags complete within the cycle they are shown in.
        st_nxt.shown     = HCFD_ZERO; // RULE20
        tool_start       = 1'b0;
        store_start      = 1'b0;
        herase_start     = 1'b0;

        // Job completions update the status flags; a fresh set wins over a clear.
        if (tool_fin) begin
            st_nxt.flash_cfg = 1'b0; // RULE4
        end
        if (tool_config_loaded) begin
            st_nxt.flash_cfg = 1'b1;
        end
        if (herase_fin) begin
            st_nxt.host_cfg = 1'b0; // RULE15
        end
        if (store_fin) begin
            st_nxt.host_cfg = 1'b1; // RULE6
        end

        if (bus_req.rd) begin
            st_nxt.rsp.ack = 1'b1;
            if (cmd_hit) begin
                // Pending jobs keep their bits visible until done.
                st_nxt.rsp.rdata = st_r.shown
                                 | (tool_busy   ? HCFD_M_TOOL_ERASE : HCFD_ZERO)
                                 | (store_busy  ? HCFD_M_STORE      : HCFD_ZERO)
                                 | (herase_busy ? HCFD_M_HOST_ERASE : HCFD_ZERO); // RULE24
            end
        end else if (bus_req.wr && cfg_hit) begin
            st_nxt.rsp.ack = 1'b1;
            st_nxt.rsp.exc = st_r.lock; // RULE9
        end else if (bus_req.wr && cmd_hit) begin
            if (w == HCFD_ZERO) begin
                st_nxt.rsp.ack = 1'b1; // RULE20
            end else if ((w & HCFD_M_FIELDBUS) != HCFD_ZERO) begin
                // The whole word is a code; the low bits carry no flags.
                st_nxt.rsp.ack = 1'b1; // RULE18
                if (fw_is_profinet) begin
                    st_nxt.fb_valid = 1'b1; // RULE19
                    st_nxt.fb_code  = w;
                end else begin
                    st_nxt.rsp.exc  = 1'b1; // RULE19
                end
            end else if ((w & HCFD_M_RESET) != HCFD_ZERO) begin
                // The reset preempts the rest of the word and sends no answer.
                st_nxt.dev_reset = 1'b1; // RULE22
                st_nxt.drop      = 1'b1; // RULE22
                st_nxt.act_host  = st_r.host_cfg; // RULE8
            end else begin
                // All flags of one word are resolved in this single evaluation.
                st_nxt.rsp.ack = 1'b1; // RULE23
                // Reserved bit 13 is neither decoded nor shown.
                st_nxt.shown   = w & ~(HCFD_M_RESERVED | HCFD_M_TOOL_ERASE
                                     | HCFD_M_STORE | HCFD_M_HOST_ERASE); // RULE17
                if ((w & HCFD_M_RESTART) != HCFD_ZERO) begin
                    st_nxt.restart  = 1'b1; // RULE1
                    st_nxt.drop     = 1'b1; // RULE1
                    st_nxt.act_host = st_r.host_cfg; // RULE8
                end
                if ((w & HCFD_M_PERMIT) != HCFD_ZERO) begin
                    st_nxt.net_open = 1'b1; // RULE21 RULE3
                end else if ((w & HCFD_M_INHIBIT) != HCFD_ZERO) begin
                    st_nxt.net_open = 1'b0; // RULE2
                    st_nxt.drop     = 1'b1; // RULE2
                end
                if ((w & HCFD_M_UNLOCK) != HCFD_ZERO) begin
                    st_nxt.lock = 1'b0; // RULE10 RULE11
                end else if ((w & HCFD_M_LOCK) != HCFD_ZERO) begin
                    st_nxt.lock = 1'b1; // RULE9
                end
                if ((w & HCFD_M_WDOG_DIS) != HCFD_ZERO) begin
                    st_nxt.wdg = 1'b0; // RULE13 RULE14
                end else if ((w & HCFD_M_WDOG_EN) != HCFD_ZERO) begin
                    st_nxt.wdg = 1'b1; // RULE12
                end
                // Tool erase never restarts; the host resets the device afterwards.
                tool_start = (w & HCFD_M_TOOL_ERASE) != HCFD_ZERO; // RULE4 RULE5
                if ((w & HCFD_M_STORE) != HCFD_ZERO) begin
                    if (st_r.flash_cfg) begin
                        st_nxt.rsp.exc = 1'b1; // RULE7
                    end else begin
                        store_start = 1'b1; // RULE6
                    end
                end
                // Only the host copy is erased; stack persistent data is not addressed.
                herase_start = (w & HCFD_M_HOST_ERASE) != HCFD_ZERO; // RULE15 RULE16
            end
        end else if (bus_req.wr) begin
            st_nxt.rsp.ack = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bus_rsp                   = st_r.rsp;
    assign device_reset_req          = st_r.dev_reset;
    assign stack_restart_req         = st_r.restart;
    assign conn_drop_req             = st_r.drop;
    assign net_open_enable           = st_r.net_open;
    assign watchdog_active           = st_r.wdg;
    assign config_write_lock         = st_r.lock;
    assign flash_config_present_flag = st_r.flash_cfg;
    assign host_config_present_flag  = st_r.host_cfg;
    assign active_config_is_host     = st_r.act_host;
    assign fb_cmd_valid              = st_r.fb_valid;
    assign fb_cmd_code               = st_r.fb_code;
endmodule

/* hcfd_flash_model.sv */
// Flash engine model that answers erase and store requests promptly or slowly.
`timescale 1ns/10ps
module hcfd_flash_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // Job requests and completions, bit 0 tool erase, bit 1 store, bit 2 host erase
    input  wire logic       slow,
    input  wire logic [2:0] req,
    output logic      [2:0] done
);
    int cnt [3];
    always_ff @(posedge clk) begin
        for (int i = 0; i < 3; i++) begin
            done[i] <= 1'b0;
            if (!nrst) cnt[i] <= 0;
            else if (req[i]) cnt[i] <= slow ? 9 : 2;
            else if (cnt[i] == 1) begin
                cnt[i] <= 0;
                done[i] <= 1'b1;
            end else if (cnt[i] > 1) cnt[i] <= cnt[i] - 1;
        end
    end
endmodule

/* hcfd_chk.sv */
// Concurrent checks on the command flag decoder ports.
`timescale 1ns/10ps
module hcfd_chk (
    // Clock and reset
    input wire logic                    clk,
    input wire logic                    nrst,
    // Bus and environment
    input wire hcfd_pkg::hcfd_bus_req_t bus_req,
    input wire hcfd_pkg::hcfd_bus_rsp_t bus_rsp,
    input wire logic                    fw_is_profinet,
    input wire logic                    flash_config_present_flag,
    // Outputs watched
    input wire logic                    device_reset_req,
    input wire logic                    stack_restart_req,
    input wire logic                    conn_drop_req,
    input wire logic                    net_open_enable,
    input wire logic                    watchdog_active,
    input wire logic                    config_write_lock,
    input wire logic                    store_req,
    input wire logic                    fb_cmd_valid,
    input wire logic [15:0]             fb_cmd_code
);
    import hcfd_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [15:0] d;
    logic        wc;
    logic        cw;
    logic        fbw;
    logic        cfg;
    assign d = bus_req.wdata;
    assign wc = bus_req.wr && !bus_req.rd && bus_req.addr == HCFD_CMD_ADDR;
    assign cw = wc && d[15:14] == 2'b00 && !d[0];
    assign fbw = wc && d[15:14] != 2'b00;
    assign cfg = bus_req.wr && !bus_req.rd && ((bus_req.addr >= HCFD_CFG_A_LO && bus_req.addr <= HCFD_CFG_A_HI)
                 || (bus_req.addr >= HCFD_CFG_B_LO && bus_req.addr <= HCFD_CFG_B_HI));
    a_restart_drops: assert property (cw && d[4] |=> stack_restart_req && conn_drop_req)
        else $error("restart without pulses");
    a_inhibit_closes: assert property (cw && d[5] && !d[3] |=> !net_open_enable && conn_drop_req)
        else $error("inhibit did not close");
    a_permit_wins: assert property (cw && d[3] |=> net_open_enable)
        else $error("permit not in force");
    a_store_refused: assert property (cw && d[7] && flash_config_present_flag |=> bus_rsp.exc && !store_req)
        else $error("store not refused");
    a_lock_rejects: assert property (config_write_lock && cfg |=> bus_rsp.ack && bus_rsp.exc)
        else $error("locked write accepted");
    a_lock_sets: assert property (cw && d[8] && !d[9] |=> config_write_lock)
        else $error("lock flag not set");
    a_unlock_wins: assert property (cw && d[9] |=> !config_write_lock)
        else $error("unlock not honoured");
    a_watchdog_enable_cmd: assert property (cw && d[10] && !d[11] |=> watchdog_active)
        else $error("watchdog not active");
    a_watchdog_disable_cmd_wins: assert property (cw && d[11] |=> !watchdog_active)
        else $error("watchdog still active");
    a_fb_code: assert property (fbw && fw_is_profinet |=> fb_cmd_valid && fb_cmd_code == $past(d))
        else $error("fieldbus code lost");
    a_fb_refused: assert property (fbw && !fw_is_profinet |=> bus_rsp.exc && !fb_cmd_valid)
        else $error("fieldbus code not refused");
    a_reset_silent: assert property (wc && d[15:14] == 2'b00 && d[0] |=> device_reset_req && !bus_rsp.ack)
        else $error("reset bit answered");
endmodule
bind hcfd_top hcfd_chk hcfd_chk_inst (.clk(clk), .nrst(nrst), .bus_req(bus_req), .bus_rsp(bus_rsp),
    .fw_is_profinet(fw_is_profinet), .flash_config_present_flag(flash_config_present_flag),
    .device_reset_req(device_reset_req), .stack_restart_req(stack_restart_req), .conn_drop_req(conn_drop_req),
    .net_open_enable(net_open_enable), .watchdog_active(watchdog_active), .config_write_lock(config_write_lock),
    .store_req(store_req), .fb_cmd_valid(fb_cmd_valid), .fb_cmd_code(fb_cmd_code));

/* hcfd_top_tb.sv */
// Self-checking bench comparing the command flag decoder with a reference model.
`timescale 1ns/10ps
module hcfd_top_tb;
    import hcfd_pkg::*;
    logic          clk, nrst, prof, tload, slow;
    hcfd_bus_req_t req;
    hcfd_bus_rsp_t rsp;
    logic [2:0]    jreq, jdone;
    logic          dres, rst_q, drop, neten, wdg, lock, ffl, hfl, act, fbv;
    logic [15:0]   fbc;
    logic [31:0]   seed = 62287;
    int            error_cnt = 0;
    int            n_tests = 0;
    bit            m_net, m_wdg, m_lock, m_ffl, m_hfl, m_act;
    logic [15:0]   ca [8] = '{16'h0064, 16'h00C7, 16'h012C, 16'h03DB, 16'h0063, 16'h00C8, 16'h012B, 16'h03DC};
    logic [15:0]   fc [5] = '{16'hB015, 16'hB010, 16'hC000, 16'hC002, 16'hC008};

    hcfd_top hcfd_top_inst (.clk(clk), .nrst(nrst), .bus_req(req), .bus_rsp(rsp), .fw_is_profinet(prof),
        .tool_config_loaded(tload), .tool_erase_done(jdone[0]), .store_done(jdone[1]), .host_erase_done(jdone[2]),
        .device_reset_req(dres), .stack_restart_req(rst_q), .conn_drop_req(drop), .net_open_enable(neten),
        .watchdog_active(wdg), .config_write_lock(lock), .flash_config_present_flag(ffl),
        .host_config_present_flag(hfl), .active_config_is_host(act), .tool_erase_req(jreq[0]),
        .store_req(jreq[1]), .host_erase_req(jreq[2]), .fb_cmd_valid(fbv), .fb_cmd_code(fbc));
    hcfd_flash_model hcfd_flash_model_inst (.clk(clk), .nrst(nrst), .slow(slow), .req(jreq), .done(jdone));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    function automatic logic [15:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction

    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tally_and_finish();
        if (error_cnt == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // One access: request held over one taking edge, answer looked at in the cycle after it.
    task automatic acc(bit rd, logic [15:0] a, logic [15:0] d, bit e_ack, bit e_exc, logic [15:0] e_rd);
        @(posedge clk) #2;
        req = '{wr: !rd, rd: rd, addr: a, wdata: d};
        @(posedge clk) #2;
        req = '0;
        chk("ack", e_ack, rsp.ack);
        chk("exc", e_exc, rsp.exc);
        if (rd) chk("rdata", e_rd, rsp.rdata);
    endtask

    task automatic cmd(logic [15:0] w);
        bit          fb, rs, inh, st;
        logic [15:0] pm;
        fb = w[15:14] != 2'b00;
        rs = w[4] & !fb;
        inh = w[5] & !w[3] & !fb;
        st = w[7] & !m_ffl & !fb;
        pm = fb ? 16'h0000 : (w & 16'h1040) | (st ? 16'h0080 : 16'h0000);
        acc(0, HCFD_CMD_ADDR, w, 1, fb ? !prof : w[7] & m_ffl, 0);
        if (!fb && w[3]) m_net = 1;
        else if (inh) m_net = 0;
        if (!fb && w[9]) m_lock = 0;
        else if (!fb && w[8]) m_lock = 1;
        if (!fb && w[11]) m_wdg = 0;
        else if (!fb && w[10]) m_wdg = 1;
        if (rs) m_act = m_hfl;
        chk("restart", rs, rst_q);
        chk("drop", rs | inh, drop);
        chk("jobs", pm, {3'b000, jreq[2], 4'b0000, jreq[1], jreq[0], 6'b000000});
        chk("fb_code", fb & prof ? w : 16'h0000, fbv ? fbc : 16'h0000);
        chk("net", m_net, neten);
        chk("wdg", m_wdg, wdg);
        chk("lock", m_lock, lock);
        if (pm != 16'h0000) begin
            acc(1, HCFD_CMD_ADDR, 0, 1, 0, pm);
            repeat (12) @(posedge clk);
            m_ffl = m_ffl & !w[6];
            m_hfl = st | (m_hfl & !w[12]);
            acc(1, HCFD_CMD_ADDR, 0, 1, 0, 0);
        end
        chk("flags", {m_ffl, m_hfl, m_act}, {ffl, hfl, act});
    endtask

    initial begin
        #2000000;
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        nrst = 1'b0;
        req = '0;
        prof = 1'b0;
        tload = 1'b0;
        slow = 1'b0;
        repeat (2) @(posedge clk);
        #2;
        nrst = 1'b1;
        acc(1, 16'h0005, 0, 1, 0, 0);
        acc(0, 16'h0005, rnd(), 1, 0, 0);
        cmd(16'h0000);
        cmd(16'h0028);
        cmd(16'h0020);
        cmd(16'h0018);
        cmd(16'h0C00);
        cmd(16'h0300);
        repeat (24) cmd(rnd() & 16'h0F28);
        cmd(16'h0100);
        foreach (ca[i]) acc(0, ca[i], rnd(), 1, i < 4, 0);
        cmd(16'h0300);
        foreach (ca[i]) acc(0, ca[i], rnd(), 1, 0, 0);
        @(posedge clk) #2;
        tload = 1'b1;
        @(posedge clk) #2;
        tload = 1'b0;
        m_ffl = 1;
        cmd(16'h0080);
        cmd(16'h0040);
        slow = 1'b1;
        cmd(16'h0080);
        cmd(16'h0018);
        cmd(16'h1000);
        for (int p = 0; p < 2; p++) begin
            prof = p[0];
            foreach (fc[i]) cmd(fc[i]);
        end
        acc(0, HCFD_CMD_ADDR, 16'h0011, 0, 0, 0);
        chk("dev_reset", 1, dres);
        chk("reset_drop", 1, drop);
        nrst = 1'b0;
        repeat (2) @(posedge clk);
        #2;
        nrst = 1'b1;
        chk("after_reset", 0, {neten, wdg, lock});
        tally_and_finish();
    end
endmodule
